// File: design/tc816_pkg.sv
/*
 * tc816_pkg: shared constants for the 8/16-bit timer/counter.
 * assumes: byte-wide register port, one 100 MHz clock.
 */
package tc816_pkg;
    // register addresses (byte port)
    localparam logic [3:0] ADDR_CNT_LO = 4'h0;
    localparam logic [3:0] ADDR_CNT_HI = 4'h1;
    localparam logic [3:0] ADDR_CMP_A = 4'h2;
    localparam logic [3:0] ADDR_CMP_B = 4'h3;
    localparam logic [3:0] ADDR_CTRL_A = 4'h4;
    localparam logic [3:0] ADDR_CTRL_B = 4'h5;
    localparam logic [3:0] ADDR_FLAGS = 4'h6;
    localparam logic [3:0] ADDR_MASK = 4'h7;
    // control a fields
    localparam int CTRL_A_WIDE_BIT = 0;
    localparam int CTRL_A_CTC_BIT = 1;
    localparam int CTRL_A_CAPEN_BIT = 2;
    localparam int CTRL_A_CAPEDGE_BIT = 3;
    // control b clock select field
    localparam int CS_LSB = 0;
    localparam int CS_W = 3;
    localparam logic [2:0] CS_NONE = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    // flag / mask bit positions
    localparam int FLG_OVF = 0;
    localparam int FLG_CMPA = 1;
    localparam int FLG_CMPB = 2;
    localparam int FLG_CAP = 3;
    localparam int NUM_FLAGS = 4;
    // count limits
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX8_VAL = 8'hff;
    localparam logic [15:0] MAX16_VAL = 16'hffff;
    // prescaler
    localparam int PRESC_W = 10;
    localparam logic [9:0] TAP8 = 10'h007;
    localparam logic [9:0] TAP64 = 10'h03f;
    localparam logic [9:0] TAP256 = 10'h0ff;
    localparam logic [9:0] TAP1024 = 10'h3ff;
endpackage : tc816_pkg

// File: design/tc816_sync.sv
/*
 * tc816_sync: two-flop synchroniser with edge pulses.
 * assumes: async input, single clock, reset already synchronised.
 */
module tc816_sync (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // asynchronous pin
    input wire logic pin_i,
    // synchronised level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta_q; // first stage, read only by sync_q
    logic sync_q; // second stage
    logic prev_q; // previous synced sample

    // two-stage capture
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
        end
    end

    // edge history
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= sync_q;
        end
    end

    assign level_o = sync_q;
    assign rise_o = sync_q & ~prev_q;
    assign fall_o = ~sync_q & prev_q;
endmodule : tc816_sync

// File: design/tc816_timer.sv
/*
 * tc816_timer: 8/16-bit timer/counter with prescaler, external clock,
 * two compare units, input capture and four interrupt sources.
 * assumes: byte register port with read data one cycle after the strobe,
 * asynchronous pins synchronised here.
 */
// Local design decisions: strobed register access and the address map.
// Summary of operation
// RULE_01: counter runs eight or sixteen bit wide
// RULE_02: two compares narrow, one compare wide
// RULE_03: wide compare is b high, a low
// RULE_04: count low and compares are bytes
// RULE_05: overflow, compare a, b, capture flags
// RULE_06: each flag has its own mask
// RULE_07: bottom means count equals zero
// RULE_08: maximum means narrow count all ones
// RULE_09: top is maximum or compare a
// RULE_10: clear on match restarts from zero
// RULE_11: capture stamps count into compare registers
// RULE_12: tick from prescaler or external pin
// RULE_13: three-bit clock select picks source, edge
// RULE_14: select zero stops all ticks
// RULE_15: host uses high byte latch, fixed order
// RULE_16: taps 1,8,64,256,1024; prescaler free-running
// RULE_17: code 7 rising, 6 falling external edge
// RULE_18: pin synchronised every clock before edges
// RULE_19: host count write beats clear or count
module tc816_timer (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // pins
    input wire logic external_count_pin_i,
    input wire logic capture_pin_i,
    // interrupt and status
    output logic irq_o,
    output logic timer_tick_o
);
    logic rst_meta_q; // reset release stage 1
    logic rst_n_q; // synchronised reset
    logic [15:0] count_q; // counter_high_byte:counter_low_byte
    logic [7:0] compare_a_value_q;
    logic [7:0] compare_b_value_q;
    logic [7:0] ctrl_a_q; // mode bits
    logic [7:0] timer_control_b_q; // clock select
    logic [3:0] timer_flag_register_q;
    logic [3:0] timer_mask_register_q;
    logic [7:0] temp_hi_q; // shared high-byte latch
    logic [9:0] presc_q; // free-running prescaler
    logic [7:0] rdata_q;
    logic ext_rise, ext_fall, cap_rise, cap_fall;
    logic tick;
    logic wide, ctc, cap_en;
    logic [2:0] cs;
    logic [15:0] top_val, count_d;
    logic hit_top, cmp_a_hit, cmp_b_hit, ovf_ev, cap_ev;
    logic cnt_wr;
    logic [3:0] ev_vec;

    // reset release through two flops
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // pin synchronisers; edge logic only sees the second stage
    tc816_sync u_ext_sync ( // RULE_18
        .clock_i(clock_i),
        .rst_n_i(rst_n_q),
        .pin_i(external_count_pin_i),
        .level_o(),
        .rise_o(ext_rise),
        .fall_o(ext_fall)
    );
    tc816_sync u_cap_sync (
        .clock_i(clock_i),
        .rst_n_i(rst_n_q),
        .pin_i(capture_pin_i),
        .level_o(),
        .rise_o(cap_rise),
        .fall_o(cap_fall)
    );

    assign wide = ctrl_a_q[tc816_pkg::CTRL_A_WIDE_BIT]; // RULE_01
    assign ctc = ctrl_a_q[tc816_pkg::CTRL_A_CTC_BIT];
    assign cap_en = ctrl_a_q[tc816_pkg::CTRL_A_CAPEN_BIT];
    assign cs = timer_control_b_q[tc816_pkg::CS_LSB +: tc816_pkg::CS_W];

    // prescaler never stops, independent of clock select
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            presc_q <= '0;
        end else begin
            presc_q <= presc_q + 10'h001; // RULE_16
        end
    end

    // tap match helper, used for all four divided rates
    function automatic logic tap_hit(input logic [9:0] cnt, input logic [9:0] mask);
        tap_hit = ((cnt & mask) == mask);
    endfunction : tap_hit

    // clock select decode; no source gives no tick
    always_comb begin
        case (cs) // RULE_13
            tc816_pkg::CS_NONE: tick = 1'b0; // RULE_14
            tc816_pkg::CS_DIV1: tick = 1'b1; // RULE_12
            tc816_pkg::CS_DIV8: tick = tap_hit(presc_q, tc816_pkg::TAP8); // RULE_16
            tc816_pkg::CS_DIV64: tick = tap_hit(presc_q, tc816_pkg::TAP64);
            tc816_pkg::CS_DIV256: tick = tap_hit(presc_q, tc816_pkg::TAP256);
            tc816_pkg::CS_DIV1024: tick = tap_hit(presc_q, tc816_pkg::TAP1024);
            tc816_pkg::CS_EXT_FALL: tick = ext_fall; // RULE_17
            tc816_pkg::CS_EXT_RISE: tick = ext_rise; // RULE_17
            default: tick = 1'b0;
        endcase
    end
    assign timer_tick_o = tick;

    // top: compare value in clear-on-match, else maximum
    always_comb begin
        if (wide) begin
            top_val = ctc ? {compare_b_value_q, compare_a_value_q} // RULE_03 RULE_09
                          : tc816_pkg::MAX16_VAL;
        end else begin
            top_val = ctc ? {8'h00, compare_a_value_q} // RULE_09
                          : {8'h00, tc816_pkg::MAX8_VAL}; // RULE_08
        end
    end

    assign hit_top = tick && (count_q == top_val);
    // maximum reached: overflow event
    assign ovf_ev = tick && (wide ? (count_q == tc816_pkg::MAX16_VAL)
                                  : (count_q[7:0] == tc816_pkg::MAX8_VAL)); // RULE_08
    // compare units: two narrow, one joined wide
    assign cmp_a_hit = tick && (wide ? (count_q == {compare_b_value_q, compare_a_value_q}) // RULE_02 RULE_03
                                     : (count_q[7:0] == compare_a_value_q));
    assign cmp_b_hit = tick && !wide && (count_q[7:0] == compare_b_value_q); // RULE_02
    // capture edge chosen by control bit
    assign cap_ev = cap_en && (ctrl_a_q[tc816_pkg::CTRL_A_CAPEDGE_BIT] ? cap_rise : cap_fall);

    assign cnt_wr = wr_i && (addr_i == tc816_pkg::ADDR_CNT_LO);

    // next count
    always_comb begin
        count_d = count_q;
        if (hit_top) begin
            count_d = {8'h00, tc816_pkg::BOTTOM_VAL}; // RULE_07 RULE_10
        end else if (tick) begin
            count_d = count_q + 16'h0001;
        end
        if (!wide) begin
            count_d[15:8] = 8'h00; // RULE_04
        end
    end

    // counter; host write of the low byte wins over count and clear
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            count_q <= '0;
        end else if (cnt_wr) begin
            count_q <= {wide ? temp_hi_q : 8'h00, wdata_i}; // RULE_19 RULE_15
        end else begin
            count_q <= count_d;
        end
    end

    // high-byte latch: written before low byte, filled on low-byte read
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            temp_hi_q <= '0;
        end else if (wr_i && (addr_i == tc816_pkg::ADDR_CNT_HI)) begin
            temp_hi_q <= wdata_i; // RULE_15
        end else if (rd_i && (addr_i == tc816_pkg::ADDR_CNT_LO)) begin
            temp_hi_q <= count_q[15:8]; // RULE_15
        end
    end

    // compare registers double as capture storage
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            compare_a_value_q <= '0;
            compare_b_value_q <= '0;
        end else if (cap_ev) begin
            compare_a_value_q <= count_q[7:0]; // RULE_11
            if (wide) begin
                compare_b_value_q <= count_q[15:8]; // RULE_11
            end
        end else if (wr_i) begin
            if (addr_i == tc816_pkg::ADDR_CMP_A) begin
                compare_a_value_q <= wdata_i; // RULE_04
            end
            if (addr_i == tc816_pkg::ADDR_CMP_B) begin
                compare_b_value_q <= wdata_i;
            end
        end
    end

    // control registers
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_a_q <= '0;
            timer_control_b_q <= '0;
        end else if (wr_i) begin
            if (addr_i == tc816_pkg::ADDR_CTRL_A) begin
                ctrl_a_q <= wdata_i;
            end
            if (addr_i == tc816_pkg::ADDR_CTRL_B) begin
                timer_control_b_q <= wdata_i;
            end
        end
    end

    // mask register
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_mask_register_q <= '0;
        end else if (wr_i && (addr_i == tc816_pkg::ADDR_MASK)) begin
            timer_mask_register_q <= wdata_i[3:0]; // RULE_06
        end
    end

    assign ev_vec = {cap_ev, cmp_b_hit, cmp_a_hit, ovf_ev}; // RULE_05

    // sticky flags: a read clears, a new event in the same cycle wins
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_flag_register_q <= '0;
        end else if (rd_i && (addr_i == tc816_pkg::ADDR_FLAGS)) begin
            timer_flag_register_q <= ev_vec; // RULE_05
        end else begin
            timer_flag_register_q <= timer_flag_register_q | ev_vec;
        end
    end

    // level interrupt from unmasked flags
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(timer_flag_register_q & timer_mask_register_q); // RULE_06
        end
    end

    // read mux; unmapped addresses answer zero
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= '0;
        end else if (rd_i) begin
            case (addr_i)
                tc816_pkg::ADDR_CNT_LO: rdata_q <= count_q[7:0];
                tc816_pkg::ADDR_CNT_HI: rdata_q <= wide ? temp_hi_q : 8'h00; // RULE_15
                tc816_pkg::ADDR_CMP_A: rdata_q <= compare_a_value_q;
                tc816_pkg::ADDR_CMP_B: rdata_q <= compare_b_value_q;
                tc816_pkg::ADDR_CTRL_A: rdata_q <= ctrl_a_q;
                tc816_pkg::ADDR_CTRL_B: rdata_q <= timer_control_b_q;
                tc816_pkg::ADDR_FLAGS: rdata_q <= {4'h0, timer_flag_register_q};
                tc816_pkg::ADDR_MASK: rdata_q <= {4'h0, timer_mask_register_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign rdata_o = rdata_q;

    // checks
    property p_stop;
        @(posedge clock_i) disable iff (!rst_n_q)
        // a leftover wide high byte is dropped when narrow mode is entered
        (cs == tc816_pkg::CS_NONE) && !cnt_wr && (wide || (count_q[15:8] == 8'h00))
            |=> (count_q == $past(count_q));
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved with no clock"); // RULE_14

    property p_wr_wins;
        @(posedge clock_i) disable iff (!rst_n_q)
        cnt_wr |=> (count_q[7:0] == $past(wdata_i));
    endproperty
    a_wr_wins: assert property (p_wr_wins) else $error("count write lost"); // RULE_19

    property p_ctc;
        @(posedge clock_i) disable iff (!rst_n_q)
        ctc && hit_top && !cnt_wr |=> (count_q == 16'h0000);
    endproperty
    a_ctc: assert property (p_ctc) else $error("no clear on match"); // RULE_10

    property p_narrow;
        @(posedge clock_i) disable iff (!rst_n_q)
        !wide |=> (count_q[15:8] == 8'h00) || $past(wide);
    endproperty
    a_narrow: assert property (p_narrow) else $error("high byte used in narrow mode"); // RULE_01

    property p_ovf;
        @(posedge clock_i) disable iff (!rst_n_q)
        ovf_ev |=> timer_flag_register_q[tc816_pkg::FLG_OVF];
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag not set"); // RULE_05

    property p_irq;
        @(posedge clock_i) disable iff (!rst_n_q)
        |(timer_flag_register_q & timer_mask_register_q) |=> irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing"); // RULE_06

    // undivided select must advance the count on every cycle
    property p_div1;
        @(posedge clock_i) disable iff (!rst_n_q)
        (cs == tc816_pkg::CS_DIV1) && !cnt_wr && !hit_top
            |=> (count_q[7:0] == $past(count_q[7:0]) + 8'h01);
    endproperty
    a_div1: assert property (p_div1) else $error("undivided tick missing"); // RULE_16

    sequence s_rise;
        ext_rise ##0 (cs == tc816_pkg::CS_EXT_RISE);
    endsequence
    // a synchronised rising edge moves the count by exactly one
    property p_ext;
        @(posedge clock_i) disable iff (!rst_n_q)
        s_rise ##0 (!cnt_wr && !hit_top) |=> (count_q[7:0] == $past(count_q[7:0]) + 8'h01);
    endproperty
    a_ext: assert property (p_ext) else $error("external edge not counted"); // RULE_17

    // narrow free-run wraps from all ones back to bottom
    property p_wrap;
        @(posedge clock_i) disable iff (!rst_n_q)
        !wide && !ctc && tick && (count_q[7:0] == tc816_pkg::MAX8_VAL) && !cnt_wr |=> (count_q == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to bottom"); // RULE_07

    // compare b unit is gone in wide mode, so its flag cannot rise
    property p_wide_b;
        @(posedge clock_i) disable iff (!rst_n_q)
        wide && !timer_flag_register_q[tc816_pkg::FLG_CMPB] |=> !timer_flag_register_q[tc816_pkg::FLG_CMPB];
    endproperty
    a_wide_b: assert property (p_wide_b) else $error("compare b fired in wide mode"); // RULE_02

    property p_cap;
        @(posedge clock_i) disable iff (!rst_n_q)
        cap_ev |=> (compare_a_value_q == $past(count_q[7:0])) && timer_flag_register_q[tc816_pkg::FLG_CAP];
    endproperty
    a_cap: assert property (p_cap) else $error("capture not stored"); // RULE_11
endmodule : tc816_timer

// File: tb/tb_top.sv
/*
 * tb_top: self-checking bench for the 8/16-bit timer/counter.
 * assumes: design package and modules compiled first, 100 MHz clock.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // clock, reset and register port
    logic clock_i;
    logic reset_n_i;
    logic [3:0] addr_i;
    logic [7:0] wdata_i;
    logic wr_i;
    logic rd_i;
    logic [7:0] rdata_o;
    // pins and outputs
    logic ext_pin;
    logic capture_pin_i;
    logic irq_o;
    logic timer_tick_o;
    // pulse source control
    logic src_start;
    logic [7:0] src_num;
    logic [3:0] src_half;
    logic src_busy;
    // bookkeeping
    int miscompares;
    int num_checks;
    int ticks;
    logic [7:0] lo;
    logic [7:0] hi;
    tc816_timer u_tc816_timer (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .external_count_pin_i(ext_pin),
        .capture_pin_i(capture_pin_i), .irq_o(irq_o), .timer_tick_o(timer_tick_o));
    tc816_pulse_src u_tc816_pulse_src (.clock_i(clock_i), .start_i(src_start), .num_i(src_num),
        .half_i(src_half), .pin_o(ext_pin), .busy_o(src_busy));
    // free-running clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // tick monitor: apart from host count writes and the high-byte drop on entering narrow mode, the count moves on exactly these edges
    always @(posedge clock_i) begin
        if (timer_tick_o === 1'b1) begin
            ticks++;
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask : rd
    // runs the counter with a clock select for a span, then stops it
    task automatic run(input logic [2:0] cs, input int cycles);
        ticks = 0;
        wr(tc816_pkg::ADDR_CTRL_B, {5'h00, cs});
        repeat (cycles) @(posedge clock_i);
        wr(tc816_pkg::ADDR_CTRL_B, 8'h00);
        repeat (4) @(posedge clock_i);
    endtask : run
    task automatic t_reset;
        rd(tc816_pkg::ADDR_FLAGS, lo);
        check(16'(lo), 16'h0000);
        rd(4'h8, lo);
        check(16'(lo), 16'h0000);
        wr(tc816_pkg::ADDR_CMP_A, 8'ha5);
        wr(tc816_pkg::ADDR_CMP_B, 8'h5a);
        rd(tc816_pkg::ADDR_CMP_A, lo);
        rd(tc816_pkg::ADDR_CMP_B, hi);
        check({hi, lo}, 16'h5aa5);
        rd(tc816_pkg::ADDR_CNT_HI, hi);
        check(16'(hi), 16'h0000);
        wr(tc816_pkg::ADDR_CNT_LO, 8'h37);
        run(tc816_pkg::CS_NONE, 50);
        check(16'(ticks), 16'h0000);
        rd(tc816_pkg::ADDR_CNT_LO, lo);
        check(16'(lo), 16'h0037);
    endtask : t_reset
    // every internal tap, sixteen periods each
    task automatic t_presc;
        int divs[5] = '{1, 8, 64, 256, 1024};
        for (int i = 0; i < 5; i++) begin
            wr(tc816_pkg::ADDR_CNT_LO, 8'h00);
            run(3'(i + 1), 16 * divs[i]);
            check(16'((ticks >= 16) && (ticks <= 19)), 16'h0001);
            rd(tc816_pkg::ADDR_CNT_LO, lo);
            check(16'(lo), 16'(ticks[7:0]));
        end
    endtask : t_presc
    // overflow past all ones, then masking and read-clear of the flag
    task automatic t_ovf_irq;
        wr(tc816_pkg::ADDR_MASK, 8'h00);
        wr(tc816_pkg::ADDR_CNT_LO, 8'hf0);
        rd(tc816_pkg::ADDR_FLAGS, lo);
        run(tc816_pkg::CS_DIV1, 32);
        rd(tc816_pkg::ADDR_CNT_LO, lo);
        // narrow count wraps through bottom, so only the low byte is kept
        check(16'(lo), {8'h00, 8'(8'hf0 + ticks[7:0])});
        check(16'(irq_o), 16'h0000);
        wr(tc816_pkg::ADDR_MASK, 8'h0e);
        repeat (2) @(posedge clock_i);
        check(16'(irq_o), 16'h0000);
        wr(tc816_pkg::ADDR_MASK, 8'h01);
        repeat (2) @(posedge clock_i);
        check(16'(irq_o), 16'h0001);
        rd(tc816_pkg::ADDR_FLAGS, lo);
        check(16'(lo), 16'h0001);
        repeat (2) @(posedge clock_i);
        check(16'(irq_o), 16'h0000);
        rd(tc816_pkg::ADDR_FLAGS, lo);
        check(16'(lo), 16'h0000);
    endtask : t_ovf_irq
    // both external edges, prompt and slow source
    task automatic t_ext;
        for (int i = 0; i < 4; i++) begin
            wr(tc816_pkg::ADDR_CNT_LO, 8'h00);
            ticks = 0;
            wr(tc816_pkg::ADDR_CTRL_B, (i < 2) ? 8'h07 : 8'h06);
            src_num <= 8'h05;
            src_half <= (i % 2 == 0) ? 4'h2 : 4'h7;
            src_start <= 1'b1;
            @(posedge clock_i);
            src_start <= 1'b0;
            // busy shows only after the edge that took the start request
            @(posedge clock_i);
            for (int k = 0; k < 200 && src_busy !== 1'b0; k++) @(posedge clock_i);
            repeat (6) @(posedge clock_i);
            wr(tc816_pkg::ADDR_CTRL_B, 8'h00);
            check(16'(ticks), 16'h0005);
            rd(tc816_pkg::ADDR_CNT_LO, lo);
            check(16'(lo), 16'h0005);
        end
    endtask : t_ext
    // clear on match: count runs 0..9 and wraps to bottom
    task automatic t_ctc;
        wr(tc816_pkg::ADDR_CTRL_A, 8'h02);
        wr(tc816_pkg::ADDR_CMP_A, 8'h09);
        wr(tc816_pkg::ADDR_CNT_LO, 8'h00);
        rd(tc816_pkg::ADDR_FLAGS, lo);
        run(tc816_pkg::CS_DIV1, 22);
        rd(tc816_pkg::ADDR_CNT_LO, lo);
        check(16'(lo), 16'(ticks % 10));
        rd(tc816_pkg::ADDR_FLAGS, lo);
        check(16'(lo), 16'h0002);
    endtask : t_ctc
    // wide mode: joined compare, no b unit, high byte order
    task automatic t_wide;
        int total;
        wr(tc816_pkg::ADDR_CTRL_A, 8'h01);
        wr(tc816_pkg::ADDR_CMP_A, 8'h05);
        wr(tc816_pkg::ADDR_CMP_B, 8'h01);
        wr(tc816_pkg::ADDR_CNT_HI, 8'h00);
        wr(tc816_pkg::ADDR_CNT_LO, 8'h00);
        rd(tc816_pkg::ADDR_FLAGS, lo);
        run(tc816_pkg::CS_DIV1, 16);
        total = ticks;
        rd(tc816_pkg::ADDR_FLAGS, lo);
        check(16'(lo), 16'h0000);
        run(tc816_pkg::CS_DIV1, 256);
        total += ticks;
        rd(tc816_pkg::ADDR_CNT_LO, lo);
        rd(tc816_pkg::ADDR_CNT_HI, hi);
        check({hi, lo}, 16'(total));
        rd(tc816_pkg::ADDR_FLAGS, lo);
        check(16'(lo), 16'h0002);
    endtask : t_wide
    // capture on the edge that ctrl selects, with the counter held still
    task automatic t_cap(input logic [7:0] ctrl, input logic [7:0] c_hi, input logic [7:0] exp_b);
        wr(tc816_pkg::ADDR_CTRL_A, ctrl);
        wr(tc816_pkg::ADDR_CMP_B, 8'h77);
        wr(tc816_pkg::ADDR_CNT_HI, c_hi);
        wr(tc816_pkg::ADDR_CNT_LO, 8'h42);
        rd(tc816_pkg::ADDR_FLAGS, lo);
        capture_pin_i <= 1'b1;
        repeat (8) @(posedge clock_i);
        capture_pin_i <= 1'b0;
        repeat (8) @(posedge clock_i);
        rd(tc816_pkg::ADDR_CMP_A, lo);
        rd(tc816_pkg::ADDR_CMP_B, hi);
        check({hi, lo}, {exp_b, 8'h42});
        rd(tc816_pkg::ADDR_FLAGS, lo);
        check(16'(lo), 16'h0008);
    endtask : t_cap
    task automatic report_and_stop;
        if (miscompares == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : report_and_stop
    // watchdog: the whole sequence needs about 22600 cycles
    initial begin
        repeat (40000) @(posedge clock_i);
        miscompares++;
        report_and_stop();
    end
    // main sequence
    initial begin
        miscompares = 0;
        num_checks = 0;
        ticks = 0;
        reset_n_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        capture_pin_i = 1'b0;
        src_start = 1'b0;
        src_num = 8'h00;
        src_half = 4'h2;
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        t_reset();
        t_presc();
        t_ovf_irq();
        t_ext();
        t_ctc();
        t_wide();
        t_cap(8'h0c, 8'h00, 8'h77);
        t_cap(8'h0d, 8'h12, 8'h12);
        t_cap(8'h04, 8'h00, 8'h77);
        report_and_stop();
    end
endmodule : tb_top

// File: tb/tc816_pulse_src.sv
/*
 * tc816_pulse_src: model of the pulse source on the external count pin.
 * assumes: one-cycle start request while idle; caller keeps half_i at two
 * or more, as slower sampling would miss edges.
 */
module tc816_pulse_src (
    // clock
    input wire logic clock_i,
    // burst request
    input wire logic start_i,
    input wire logic [7:0] num_i,
    input wire logic [3:0] half_i,
    // pin and status
    output logic pin_o,
    output logic busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] halves_q; // pin toggles still to make
    logic [3:0] dwell_q; // cycles left in this half period
    // pin idles low so the count logic sees a stable level when enabled
    initial begin
        pin_o = 1'b0;
        busy_o = 1'b0;
    end
    // burst engine: each half period lasts half_i cycles, ends low
    always @(posedge clock_i) begin
        if (!busy_o) begin
            if (start_i) begin
                busy_o <= 1'b1;
                halves_q <= {num_i, 1'b0};
                dwell_q <= half_i;
            end
        end else if (dwell_q > 4'h1) begin
            dwell_q <= dwell_q - 4'h1;
        end else if (halves_q != 9'h000) begin
            pin_o <= ~pin_o;
            halves_q <= halves_q - 9'h001;
            dwell_q <= half_i;
        end else begin
            busy_o <= 1'b0; // low level held a full half before release
        end
    end
endmodule : tc816_pulse_src
